// ==== clk_sel_top.sv ====
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module clk_sel_top
  import clk_sel_pkg::*;
(
  // bus clock and hard reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // strap pins
  input  wire logic [4:0]  EXT_MULT_STRAPS,
  input  wire logic [1:0]  EXT_RANGE_STRAPS,
  // loop controls
  output loop_cfg_s        FIRST_LOOP_CFG,
  output logic             FIRST_LOOP_ENABLE,
  output loop_cfg_s        SECOND_LOOP_CFG,
  output logic             SECOND_LOOP_ENABLE,
  // core clock selection
  output logic             CORE_FROM_FIRST_EN,
  output logic             CORE_FROM_SECOND_EN,
  output logic             CORE_BYPASS,
  output logic             CORE_CLOCK_RUN,
  output logic      [5:0]  CORE_BUS_RATIO,
  output logic             LOOP_SELECT_STATUS,
  output logic             CORE_EXEC_EN
);

  typedef struct packed {
    logic [6:0]  strap_s1;
    logic [6:0]  strap_s2;
    logic [6:0]  strap_latch;
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic        fault;
    logic        run;
  } top_s;

  top_s q;
  top_s d;

  loop_mode_s mode0;
  loop_mode_s mode1;
  loop_mode_s act_mode;
  loop_mode_s tgt_mode;
  loop_cfg_s  cfg0;
  loop_cfg_s  cfg1;
  logic       active;
  logic       busy;
  logic       en_first;
  logic       en_second;
  logic       setup_rd;
  logic       access;
  logic       wr_cfg;
  logic       wr_stat;
  logic       fault_evt;
  logic [31:0] cfg_view;
  logic [31:0] stat_view;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
    return a == o;
  endfunction

  // first loop follows the straps caught at reset unless internally steered
  assign cfg0 = q.cfg[INT_CTL_BIT] ?
                loop_cfg_s'({q.cfg[L0_RANGE_LSB +: 2],
                             q.cfg[L0_MULT_LSB +: 5]}) :
                loop_cfg_s'(q.strap_latch);
  assign cfg1 = loop_cfg_s'({q.cfg[L1_RANGE_LSB +: 2],
                             q.cfg[L1_MULT_LSB +: 5]});

  loop_mode_decode u_dec0 (
    .cfg  (cfg0),
    .mode (mode0)
  );

  loop_mode_decode u_dec1 (
    .cfg  (cfg1),
    .mode (mode1)
  );

  loop_switch u_switch (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .sel_req   (q.cfg[SEL_BIT]),
    .active    (active),
    .busy      (busy),
    .en_first  (en_first),
    .en_second (en_second)
  );

  assign act_mode = active ? mode1 : mode0;
  assign tgt_mode = PWDATA[SEL_BIT] ? mode1 : mode0;

  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign access = PSEL && PENABLE;
  assign wr_cfg = access && PWRITE && hit(PADDR, CFG_OFFSET);
  assign wr_stat = access && PWRITE && hit(PADDR, STAT_OFFSET);

  // selecting an off loop or hopping between half steps is a software slip
  assign fault_evt = wr_cfg && (PWDATA[SEL_BIT] != q.cfg[SEL_BIT]) &&
                     (tgt_mode.off || (mode0.half_step && mode1.half_step));

  assign cfg_view = {q.cfg[31:EXT_MSB+1], q.strap_s2};

  always_comb begin
    stat_view = '0;
    stat_view[ST_ACTIVE] = active;
    stat_view[ST_BUSY] = busy;
    stat_view[ST_FAULT] = q.fault;
    stat_view[ST_RUN] = CORE_CLOCK_RUN;
    stat_view[ST_BYPASS] = act_mode.bypass;
    stat_view[ST_RANGE_LOW] = act_mode.range_low;
    stat_view[ST_RANGE_RSVD] = act_mode.range_rsvd;
    stat_view[ST_UNSUP] = act_mode.unsupported;
    stat_view[ST_RATIO_LSB +: 6] = act_mode.ratio_x2;
  end

  always_comb begin
    d = q;
    d.strap_s1 = {EXT_RANGE_STRAPS, EXT_MULT_STRAPS};
    d.strap_s2 = q.strap_s1;
    d.run = 1'b1;
    if (setup_rd) begin
      if (hit(PADDR, CFG_OFFSET)) begin
        d.rdata = cfg_view;
      end else if (hit(PADDR, STAT_OFFSET)) begin
        d.rdata = stat_view;
      end else begin
        d.rdata = '0;
      end
    end
    if (wr_cfg) begin
      d.cfg = PWDATA & CFG_WR_MASK;
    end
    if (wr_stat && PWDATA[ST_FAULT]) begin
      d.fault = 1'b0;
    end
    // a new fault in the clearing cycle survives
    if (fault_evt) begin
      d.fault = 1'b1;
    end
    if (!RESET_N) begin
      d.cfg = CFG_RESET;
      d.strap_latch = q.strap_s2;
      d.rdata = '0;
      d.fault = 1'b0;
      d.run = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  // zero-wait slave; read data were registered in the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access &&
                   !(hit(PADDR, CFG_OFFSET) || hit(PADDR, STAT_OFFSET));
  assign PRDATA = q.rdata;

  assign FIRST_LOOP_CFG = cfg0;
  assign SECOND_LOOP_CFG = cfg1;
  // bypass parks the loop; off code powers it down
  assign FIRST_LOOP_ENABLE = !mode0.off && !mode0.bypass;
  assign SECOND_LOOP_ENABLE = !mode1.off && !mode1.bypass;
  assign CORE_FROM_FIRST_EN = en_first && !mode0.off;
  assign CORE_FROM_SECOND_EN = en_second && !mode1.off;
  assign CORE_BYPASS = act_mode.bypass;
  assign CORE_CLOCK_RUN = !act_mode.off && !busy;
  assign CORE_BUS_RATIO = act_mode.ratio_x2;
  assign LOOP_SELECT_STATUS = active;
  assign CORE_EXEC_EN = q.run && CORE_CLOCK_RUN;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  property p_reset_clear;
    $rose(RESET_N) |-> ((q.cfg & CFG_WR_MASK) == CFG_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("writable bits not clear after reset");

  property p_reset_first;
    $rose(RESET_N) |->
      (!LOOP_SELECT_STATUS && FIRST_LOOP_CFG == loop_cfg_s'(q.strap_latch));
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("first loop not on straps after reset");

  property p_strap_read;
    (setup_rd && hit(PADDR, CFG_OFFSET)) |=>
      (PRDATA[EXT_MSB:EXT_LSB] == $past(q.strap_s2));
  endproperty
  a_strap_read: assert property (p_strap_read)
    else $error("strap levels not read back");

  property p_second_fields;
    wr_cfg |=> (SECOND_LOOP_CFG.mult == $past(PWDATA[L1_MULT_LSB +: 5]));
  endproperty
  a_second_fields: assert property (p_second_fields)
    else $error("second loop ignores its fields");

  property p_second_off;
    $rose(RESET_N) |-> (!SECOND_LOOP_ENABLE && !SECOND_LOOP_CFG.range[1]);
  endproperty
  a_second_off: assert property (p_second_off)
    else $error("second loop not off after reset");

  property p_first_off;
    (q.cfg[INT_CTL_BIT] && q.cfg[L0_MULT_LSB +: 5] == 5'h00)
      |-> !FIRST_LOOP_ENABLE;
  endproperty
  a_first_off: assert property (p_first_off)
    else $error("first loop still enabled when set off");

  property p_bypass_ratio;
    CORE_BYPASS |-> (CORE_BUS_RATIO == BYPASS_RATIO);
  endproperty
  a_bypass_ratio: assert property (p_bypass_ratio)
    else $error("bypass not at 1:1");

  property p_off_stops;
    act_mode.off |-> (!CORE_CLOCK_RUN && !CORE_FROM_FIRST_EN &&
                      !CORE_FROM_SECOND_EN);
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("clock runs in off mode");

  property p_range_decode;
    (cfg0.range == RANGE_HIGH) |-> (!mode0.range_low && !mode0.range_rsvd);
  endproperty
  a_range_decode: assert property (p_range_decode)
    else $error("range 00 misdecoded");

  property p_ratio_full;
    (cfg1.mult == FULL_FIRST) |-> (mode1.ratio_x2 == 6'h14);
  endproperty
  a_ratio_full: assert property (p_ratio_full)
    else $error("code 20 not 10x");

  property p_fault_sticky;
    (fault_evt && wr_stat) |=> q.fault;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault lost while clearing");

  c_fault: cover property (fault_evt);
  c_bypass: cover property (CORE_BYPASS && CORE_CLOCK_RUN);

endmodule
`default_nettype wire

// ==== clk_sel_pkg.sv ====
// Overview of operation
// - power-on reset clears every writable configuration bit 7 to 31.
// - reset state selects the first loop, which follows the strap pins.
// - configuration bits 0-6 read back the current strap pin levels.
// - second loop always uses its own register multiplier and range fields.
// - after hard reset the second loop is off, high range (00) selected.
// - after reset release the core runs from the first loop at strap ratio.
// - setting loop select moves core to second loop within three bus cycles.
// - after a switch a status bit reports which loop clocks the core.
// - clearing loop select returns the core to the first loop.
// - first loop multiplier zero with internal control set turns it off.
// - range 00 means 600 MHz and above, 10 below, 01 and 11 reserved.
// - multiplier codes decode to off, bypass, half steps and integer ratios.
// - bypass clocks core from bus clock, loop disabled, ratio 1:1.
// - clock-off mode stops all internal clocking.
`default_nettype none
package clk_sel_pkg;

  // register byte offsets
  localparam logic [31:0] CFG_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] STAT_OFFSET   = 32'h0000_0004;

  // configuration register fields
  localparam int          EXT_LSB       = 0;
  localparam int          EXT_MSB       = 6;
  localparam int          SEL_BIT       = 7;
  localparam int          INT_CTL_BIT   = 8;
  localparam int          L0_MULT_LSB   = 9;
  localparam int          L0_RANGE_LSB  = 14;
  localparam int          L1_MULT_LSB   = 16;
  localparam int          L1_RANGE_LSB  = 21;
  localparam logic [31:0] CFG_WR_MASK   = 32'hffff_ff80;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

  // status register fields
  localparam int          ST_ACTIVE     = 0;
  localparam int          ST_BUSY       = 1;
  localparam int          ST_FAULT      = 2;
  localparam int          ST_RUN        = 3;
  localparam int          ST_BYPASS     = 4;
  localparam int          ST_RANGE_LOW  = 5;
  localparam int          ST_RANGE_RSVD = 6;
  localparam int          ST_UNSUP      = 7;
  localparam int          ST_RATIO_LSB  = 8;

  // multiplier and range codes
  localparam logic [4:0]  OFF_LO_TOP    = 5'h01;
  localparam logic [4:0]  OFF_TOP_CODE  = 5'h1f;
  localparam logic [4:0]  BYPASS_LO     = 5'h02;
  localparam logic [4:0]  BYPASS_HI     = 5'h03;
  localparam logic [4:0]  UNSUP_LO      = 5'h04;
  localparam logic [4:0]  UNSUP_HI      = 5'h05;
  localparam logic [4:0]  HALF_FIRST    = 5'h04;
  localparam logic [4:0]  HALF_LAST     = 5'h13;
  localparam logic [4:0]  FULL_FIRST    = 5'h14;
  localparam logic [4:0]  FULL_LAST     = 5'h1e;
  localparam logic [4:0]  FULL_OFFSET   = 5'h0a;
  localparam logic [5:0]  BYPASS_RATIO  = 6'h02;
  localparam logic [1:0]  RANGE_HIGH    = 2'h0;
  localparam logic [1:0]  RANGE_LOW     = 2'h2;

  // bus cycles allowed from select write to completed switch
  localparam int          SWITCH_CYCLES = 3;

  typedef struct packed {
    logic [1:0] range;
    logic [4:0] mult;
  } loop_cfg_s;

  typedef struct packed {
    logic       off;
    logic       bypass;
    logic       unsupported;
    logic       half_step;
    logic [5:0] ratio_x2;
    logic       range_low;
    logic       range_rsvd;
  } loop_mode_s;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_DROP = 3'b010,
    SW_GAP  = 3'b100
  } sw_state_e;

endpackage
`default_nettype wire

// ==== loop_mode_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module loop_mode_decode
  import clk_sel_pkg::*;
(
  // loop setting in, decoded mode out
  input  wire loop_cfg_s  cfg,
  output loop_mode_s      mode
);

  function automatic loop_mode_s decode(input loop_cfg_s c);
    loop_mode_s m;
    logic [4:0] above;
    m = '0;
    above = 5'(c.mult - FULL_OFFSET);
    m.off = (c.mult <= OFF_LO_TOP) || (c.mult == OFF_TOP_CODE);
    m.bypass = (c.mult == BYPASS_LO) || (c.mult == BYPASS_HI);
    m.unsupported = (c.mult == UNSUP_LO) || (c.mult == UNSUP_HI);
    if (m.bypass) begin
      m.ratio_x2 = BYPASS_RATIO;
    end else if (c.mult >= HALF_FIRST && c.mult <= HALF_LAST) begin
      m.ratio_x2 = {1'b0, c.mult};
      m.half_step = c.mult[0];
    end else if (c.mult >= FULL_FIRST && c.mult <= FULL_LAST) begin
      m.ratio_x2 = {above, 1'b0};
    end
    m.range_low = (c.range == RANGE_LOW);
    m.range_rsvd = c.range[0];
    return m;
  endfunction

  assign mode = decode(cfg);

endmodule
`default_nettype wire

// ==== loop_switch.sv ====
`timescale 1ns/1ps
`default_nettype none
module loop_switch
  import clk_sel_pkg::*;
(
  // clock and synchronous reset
  input  wire logic clk,
  input  wire logic reset_n,
  // requested and reported source
  input  wire logic sel_req,
  output logic      active,
  output logic      busy,
  // clock gate enables, never both high
  output logic      en_first,
  output logic      en_second
);

  typedef struct packed {
    sw_state_e state;
    logic      target;
    logic      active;
  } sw_s;

  sw_s q;
  sw_s d;

  // break-before-make: both gates closed two cycles before the new one opens
  always_comb begin
    d = q;
    case (q.state)
      SW_IDLE: begin
        if (sel_req != q.active) begin
          d.state = SW_DROP;
          d.target = sel_req;
        end
      end
      SW_DROP: d.state = SW_GAP;
      SW_GAP: begin
        d.state = SW_IDLE;
        d.active = q.target;
      end
      default: d.state = SW_IDLE;
    endcase
    if (!reset_n) begin
      d.state = SW_IDLE;
      d.target = 1'b0;
      d.active = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign active = q.active;
  assign busy = (q.state != SW_IDLE);
  assign en_first = (q.state == SW_IDLE) && !q.active;
  assign en_second = (q.state == SW_IDLE) && q.active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_switch_bound;
    (!busy && $changed(sel_req)) |-> ##[1:3] (active == sel_req && !busy);
  endproperty
  a_switch_bound: assert property (p_switch_bound)
    else $error("source switch took more than three cycles");

  property p_no_overlap;
    !(en_first && en_second);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both clock gates open");

  property p_status_after_gap;
    $changed(active) |-> $past(!en_first && !en_second, 2);
  endproperty
  a_status_after_gap: assert property (p_status_after_gap)
    else $error("status moved before gates were quiet");

  property p_back_to_first;
    (!busy && active && !sel_req) |-> ##3 (en_first && !active);
  endproperty
  a_back_to_first: assert property (p_back_to_first)
    else $error("return to first loop failed");

  // busy lasts exactly the drop and gap cycles
  c_to_second: cover property (!active ##1 busy [*2] ##1 active);
  c_to_first: cover property (active ##1 busy [*2] ##1 !active);

endmodule
`default_nettype wire

// ==== board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module board_model #(
  parameter logic [6:0] INIT_STRAPS = 7'h08
) (
  // bus clock and bench request
  input  wire logic       clk,
  input  wire logic       reset_req,
  input  wire logic [6:0] straps_next,
  // hard reset and strap pins
  output logic            reset_n,
  output logic [4:0]      mult_straps,
  output logic [1:0]      range_straps
);
  int hold = 4;
  initial begin
    reset_n = 1'b0;
    {range_straps, mult_straps} = INIT_STRAPS;
  end
  // four low edges cover the design's two strap sync stages
  always @(posedge clk) begin
    if (hold > 0) begin
      hold    <= hold - 1;
      reset_n <= (hold == 1);
    end else if (reset_req) begin
      reset_n                     <= 1'b0;
      {range_straps, mult_straps} <= straps_next;
      hold                        <= 4;
    end
  end
endmodule
`default_nettype wire

// ==== dual_pll_clock_select_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dual_pll_clock_select_test;
  import clk_sel_pkg::*;
  logic        CLK = 1'b0, RESET_N, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, PREADY, PSLVERR, reset_req = 1'b0;
  logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, rd;
  logic [4:0]  EXT_MULT_STRAPS;
  logic [1:0]  EXT_RANGE_STRAPS;
  logic [6:0]  straps_next = 7'h08;
  loop_cfg_s   FIRST_LOOP_CFG, SECOND_LOOP_CFG;
  logic        FIRST_LOOP_ENABLE, SECOND_LOOP_ENABLE, CORE_FROM_FIRST_EN;
  logic        CORE_FROM_SECOND_EN, CORE_BYPASS, CORE_CLOCK_RUN, er;
  logic        LOOP_SELECT_STATUS, CORE_EXEC_EN;
  logic [5:0]  CORE_BUS_RATIO;
  int          mismatches = 0;
  int          checks_done = 0;

  always #25 CLK = ~CLK;

  board_model board (.clk(CLK), .reset_req(reset_req),
    .straps_next(straps_next), .reset_n(RESET_N),
    .mult_straps(EXT_MULT_STRAPS), .range_straps(EXT_RANGE_STRAPS));

  clk_sel_top dut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_MULT_STRAPS(EXT_MULT_STRAPS), .EXT_RANGE_STRAPS(EXT_RANGE_STRAPS),
    .FIRST_LOOP_CFG(FIRST_LOOP_CFG), .FIRST_LOOP_ENABLE(FIRST_LOOP_ENABLE),
    .SECOND_LOOP_CFG(SECOND_LOOP_CFG),
    .SECOND_LOOP_ENABLE(SECOND_LOOP_ENABLE),
    .CORE_FROM_FIRST_EN(CORE_FROM_FIRST_EN),
    .CORE_FROM_SECOND_EN(CORE_FROM_SECOND_EN), .CORE_BYPASS(CORE_BYPASS),
    .CORE_CLOCK_RUN(CORE_CLOCK_RUN), .CORE_BUS_RATIO(CORE_BUS_RATIO),
    .LOOP_SELECT_STATUS(LOOP_SELECT_STATUS), .CORE_EXEC_EN(CORE_EXEC_EN));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one idle edge first, so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wait_release;
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (RESET_N !== 1'b1 && n < 20);
    repeat (3) @(posedge CLK);
  endtask

  task automatic board_reset(input logic [6:0] s);
    @(posedge CLK);
    straps_next <= s;
    reset_req   <= 1'b1;
    @(posedge CLK);
    reset_req <= 1'b0;
    wait_release();
  endtask

  task automatic wait_switch(input logic want);
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
      chk({31'h0, CORE_FROM_FIRST_EN & CORE_FROM_SECOND_EN}, 0, "gates");
    end while (LOOP_SELECT_STATUS !== want && n < 8);
    chk(n, 32'(SWITCH_CYCLES), "switch cycles");
    chk({30'h0, CORE_FROM_FIRST_EN, CORE_FROM_SECOND_EN},
        want ? 32'h1 : 32'h2, "gate after");
  endtask

  task automatic t_reset;
    chk({25'h0, FIRST_LOOP_CFG}, 32'h08, "first cfg");
    chk({25'h0, SECOND_LOOP_CFG}, 32'h0, "second cfg");
    chk({31'h0, SECOND_LOOP_ENABLE}, 0, "second off");
    chk({31'h0, LOOP_SELECT_STATUS}, 0, "status pin");
    chk({26'h0, CORE_BUS_RATIO}, 32'h8, "ratio");
    chk({31'h0, CORE_EXEC_EN}, 1, "exec");
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, 32'h08, "cfg reset");
    apb(1'b1, CFG_OFFSET, 32'h7f);
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, 32'h08, "cfg ro");
    apb(1'b1, 32'h8, 32'hffff_ffff);
    chk({31'h0, er}, 1, "unmapped wr err");
    apb(1'b0, 32'h8, 32'h0);
    chk({31'h0, er}, 1, "unmapped rd err");
    chk(rd, 0, "unmapped data");
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, 32'h08, "cfg kept");
    $display("test reset done");
  endtask

  task automatic t_switch;
    logic [31:0] w;
    w = 32'h8000_0000 | (32'd12 << L1_MULT_LSB) | (32'd2 << L1_RANGE_LSB);
    apb(1'b1, CFG_OFFSET, w | 32'h7f);
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rd, w | 32'h08, "cfg rw");
    chk({25'h0, SECOND_LOOP_CFG}, 32'h4c, "second cfg");
    chk({31'h0, SECOND_LOOP_ENABLE}, 1, "second on");
    w = w | (32'h1 << SEL_BIT);
    apb(1'b1, CFG_OFFSET, w);
    wait_switch(1'b1);
    chk({26'h0, CORE_BUS_RATIO}, 32'd12, "ratio second");
    w = w | (32'h1 << INT_CTL_BIT);
    apb(1'b1, CFG_OFFSET, w);
    #1;
    chk({31'h0, FIRST_LOOP_ENABLE}, 0, "first off");
    w = w | (32'd20 << L0_MULT_LSB);
    apb(1'b1, CFG_OFFSET, w);
    #1;
    chk({31'h0, FIRST_LOOP_ENABLE}, 1, "first on");
    apb(1'b1, CFG_OFFSET, w & ~(32'h1 << SEL_BIT));
    wait_switch(1'b0);
    chk({26'h0, CORE_BUS_RATIO}, 32'd20, "ratio first");
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk({30'h0, rd[ST_FAULT], rd[ST_ACTIVE]}, 0, "status active");
    $display("test switch done");
  endtask

  // each multiplier strap code applied under hard reset, range straps from its low bits, then decoded
  task automatic t_decode;
    for (int c = 0; c < 32; c++) begin
      logic [4:0] m;
      logic       off;
      logic       byp;
      logic [5:0] rx2;
      m   = c[4:0];
      off = (m <= 5'd1) || (m == 5'd31);
      byp = (m == 5'd2) || (m == 5'd3);
      rx2 = off ? 6'd0 : byp ? 6'd2 : (m <= 5'd19) ? {1'b0, m} :
            {m - 5'd10, 1'b0};
      board_reset({m[1:0], m});
      chk({28'h0, CORE_CLOCK_RUN, CORE_BYPASS, FIRST_LOOP_ENABLE,
           CORE_EXEC_EN}, {28'h0, !off, byp, !off && !byp, !off},
          "mode");
      if (m < 5'd4 || m > 5'd5) begin
        chk({26'h0, CORE_BUS_RATIO}, {26'h0, rx2}, "ratio");
      end
      apb(1'b0, STAT_OFFSET, 32'h0);
      chk({29'h0, rd[ST_UNSUP], rd[ST_RANGE_RSVD], rd[ST_RANGE_LOW]},
          {29'h0, m == 5'd4 || m == 5'd5, m[0], m[1:0] == 2'b10},
          "status decode");
    end
    $display("test decode done");
  endtask

  initial begin
    repeat (5000) @(posedge CLK);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    wait_release();
    t_reset();
    t_switch();
    t_decode();
    report_and_stop();
  end
endmodule
`default_nettype wire
